// [logic/pfb_flag_bank.sv]
// Peripheral interrupt flag bank one with a classic Wishbone register slave.
// Assumes peripherals give one-cycle strobes on clk_i and the bus master holds a request until ack.
//
// Implementation choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "pfb_defines.svh"

module pfb_flag_bank (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [7:0]      wb_adr_i,
    input  wire logic [3:0]      wb_sel_i,
    input  wire logic [31:0]     wb_dat_i,
    output var  logic [31:0]     wb_dat_o,
    output var  logic            wb_ack_o,
    input  wire pfb_pkg::pfb_evt_t evt_i,
    output var  logic [7:0]      flags_o,
    output var  logic            irq_o
);
    import pfb_pkg::*;

    function automatic logic addr_hit(input logic [7:0] adr, input logic [7:0] ofs);
        addr_hit = (adr == ofs);
    endfunction

    // Bus request and handshake.
    logic wb_req;
    logic ack_next;
    logic wr_fire;
    logic rd_take;

    assign wb_req   = wb_cyc_i & wb_stb_i;
    assign ack_next = wb_req & ~wb_ack_o;
    // Writes land on the edge where the master sees ack, once per request.
    assign wr_fire  = wb_req & wb_we_i & wb_ack_o & wb_sel_i[0];
    assign rd_take  = ack_next;

    // Address decode.
    logic hit_flag;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_mask;
    logic hit_any;

    assign hit_flag = addr_hit(wb_adr_i, `PFB_OFS_FLAG);
    assign hit_ctrl = addr_hit(wb_adr_i, `PFB_OFS_CTRL);
    assign hit_stat = addr_hit(wb_adr_i, `PFB_OFS_STAT);
    assign hit_mask = addr_hit(wb_adr_i, `PFB_OFS_MASK);
    assign hit_any  = hit_flag | hit_ctrl | hit_stat | hit_mask;

    logic flag_we;
    logic ctrl_we;
    logic stat_we;
    logic mask_we;

    assign flag_we = wr_fire & hit_flag;
    assign ctrl_we = wr_fire & hit_ctrl;
    assign stat_we = wr_fire & hit_stat;
    assign mask_we = wr_fire & hit_mask;

    // Control register: parallel port present and capture/compare mode.
    logic [7:0]    ctrl_reg;
    logic          psp_present;
    pfb_ccp_mode_t ccp_mode;

    assign psp_present = ctrl_reg[`PFB_CTRL_PSP_BIT];
    assign ccp_mode    = pfb_ccp_mode_t'(ctrl_reg[`PFB_CTRL_MODE_HI:`PFB_CTRL_MODE_LO]);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `PFB_RST_CTRL;
        end else if (ctrl_we) begin
            ctrl_reg <= {5'h00, wb_dat_i[2:0]};
        end
    end

    // Capture/compare event selection by mode; PWM and off never set it.
    logic ccp_hit;

    always_comb begin
        unique case (ccp_mode)
            PFB_CCP_CAPTURE: ccp_hit = evt_i.ccp_capture;
            PFB_CCP_COMPARE: ccp_hit = evt_i.ccp_compare;
            PFB_CCP_PWM:     ccp_hit = 1'b0;
            PFB_CCP_OFF:     ccp_hit = 1'b0;
        endcase
    end

    // Hardware set terms. No interrupt mask gates them, which is what makes polling work.
    logic [7:0] set_vec;
    logic [7:0] wr_vec;
    logic [7:0] wd_vec;
    logic [7:0] flag_val;

    assign set_vec[`PFB_BIT_PSP]  = evt_i.psp_access & psp_present;
    assign set_vec[`PFB_BIT_CONV] = evt_i.conv_done;
    assign set_vec[`PFB_BIT_RX]   = evt_i.rx_load;
    assign set_vec[`PFB_BIT_TX]   = evt_i.tx_drain;
    assign set_vec[`PFB_BIT_SYNC] = evt_i.sync_done;
    assign set_vec[`PFB_BIT_CCP]  = ccp_hit;
    assign set_vec[`PFB_BIT_TMRB] = evt_i.tmr_b_match;
    assign set_vec[`PFB_BIT_TMRA] = evt_i.tmr_a_ovf;

    // Sticky bits clear only by a software write. Receive and transmit bits
    // are read-only and follow their buffer strobes instead.
    // Without the parallel port the top bit is held clear every cycle.
    assign wr_vec[`PFB_BIT_PSP]  = flag_we | ~psp_present;
    assign wd_vec[`PFB_BIT_PSP]  = wb_dat_i[`PFB_BIT_PSP] & psp_present;
    assign wr_vec[`PFB_BIT_RX]   = evt_i.rx_read;
    assign wd_vec[`PFB_BIT_RX]   = 1'b0;
    assign wr_vec[`PFB_BIT_TX]   = evt_i.tx_write;
    assign wd_vec[`PFB_BIT_TX]   = 1'b0;
    assign wr_vec[`PFB_BIT_CONV] = flag_we;
    assign wd_vec[`PFB_BIT_CONV] = wb_dat_i[`PFB_BIT_CONV];
    assign wr_vec[3:0] = {4{flag_we}};
    assign wd_vec[3:0] = wb_dat_i[3:0];

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
            pfb_flag_cell u_cell (
                .clk_i (clk_i),
                .rst_i (rst_i),
                .set_i (set_vec[gi]),
                .wr_i  (wr_vec[gi]),
                .wd_i  (wd_vec[gi]),
                .q_o   (flag_val[gi])
            );
        end
    endgenerate

    assign flags_o = flag_val;

    // Each rising flag is an event for the sticky status register.
    logic [7:0] flag_dly_reg;
    logic [7:0] flag_rise;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_dly_reg <= `PFB_RST_FLAG;
        end else begin
            flag_dly_reg <= flag_val;
        end
    end

    assign flag_rise = flag_val & ~flag_dly_reg;

    logic [7:0] stat_val;
    logic [7:0] mask_val;
    logic [7:0] w1c_vec;

    assign w1c_vec = stat_we ? wb_dat_i[7:0] : 8'h00;

    pfb_irq_status u_irq (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .evt_i     (flag_rise),
        .w1c_i     (w1c_vec),
        .mask_we_i (mask_we),
        .mask_wd_i (wb_dat_i[7:0]),
        .stat_o    (stat_val),
        .mask_o    (mask_val),
        .irq_o     (irq_o)
    );

    // Read mux; an unmapped address answers with ack and zero data.
    logic [7:0]  rd_byte;
    logic [31:0] rd_word;

    assign rd_byte = hit_flag ? flag_val :
                     hit_ctrl ? ctrl_reg :
                     hit_stat ? stat_val :
                     hit_mask ? mask_val : 8'h00;
    assign rd_word = (hit_any & ~wb_we_i) ? {24'h000000, rd_byte} : 32'h00000000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= ack_next;
            if (rd_take) begin
                wb_dat_o <= rd_word;
            end
        end
    end

    // Checks.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic psp_dly_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            psp_dly_reg <= 1'b0;
        end else begin
            psp_dly_reg <= psp_present;
        end
    end

    AST_SET_IGNORES_MASK: assert property (
        evt_i.conv_done && mask_val == 8'h00 |=> flags_o[`PFB_BIT_CONV])
        else $error("conversion flag not set while masked");

    AST_PSP_STICKY: assert property (
        flags_o[`PFB_BIT_PSP] && !flag_we && psp_present && psp_dly_reg
        |=> flags_o[`PFB_BIT_PSP])
        else $error("parallel port flag dropped without a write");

    AST_PSP_SET: assert property (
        evt_i.psp_access && psp_present |=> flags_o[`PFB_BIT_PSP])
        else $error("parallel port access did not set flag");

    AST_CONV_CLEAR: assert property (
        flag_we && !wb_dat_i[`PFB_BIT_CONV] && !evt_i.conv_done
        |=> !flags_o[`PFB_BIT_CONV])
        else $error("conversion flag not cleared by write of zero");

    AST_RX_READ_CLEARS: assert property (
        evt_i.rx_read && !evt_i.rx_load |=> !flags_o[`PFB_BIT_RX])
        else $error("receive flag not cleared by buffer read");

    AST_RX_READ_ONLY: assert property (
        !evt_i.rx_load && !evt_i.rx_read |=> $stable(flags_o[`PFB_BIT_RX]))
        else $error("receive flag changed without a buffer strobe");

    AST_TX_FOLLOWS: assert property (
        evt_i.tx_write && !evt_i.tx_drain ##1 (!evt_i.tx_drain)[*2]
        |-> !flags_o[`PFB_BIT_TX])
        else $error("transmit flag set while buffer full");

    AST_SYNC_STICKY: assert property (
        evt_i.sync_done ##1 (!flag_we)[*3] |-> flags_o[`PFB_BIT_SYNC])
        else $error("sync serial flag lost before software clear");

    AST_TMRA_SET: assert property (
        evt_i.tmr_a_ovf |=> flags_o[`PFB_BIT_TMRA] ##1 (flags_o[`PFB_BIT_TMRA] || $past(flag_we)))
        else $error("timer A overflow flag not held");

    AST_PSP_ABSENT: assert property (
        !psp_present |=> !flags_o[`PFB_BIT_PSP])
        else $error("top flag set without parallel port");

    AST_CCP_PWM: assert property (
        ccp_mode == PFB_CCP_PWM && !flags_o[`PFB_BIT_CCP] && !flag_we
        |=> !flags_o[`PFB_BIT_CCP])
        else $error("capture/compare flag set in PWM mode");

    AST_CCP_COMPARE: assert property (
        ccp_mode == PFB_CCP_COMPARE && evt_i.ccp_compare |=> flags_o[`PFB_BIT_CCP])
        else $error("compare match did not set flag");

    AST_TMRB_SET: assert property (
        evt_i.tmr_b_match |=> flags_o[`PFB_BIT_TMRB])
        else $error("timer B match did not set flag");

    AST_POLL_READ: assert property (
        wb_req && !wb_we_i && hit_flag && !wb_ack_o
        |=> wb_ack_o && wb_dat_o[7:0] == $past(flag_val))
        else $error("flag read does not return flag state");

    AST_ACK_PULSE: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    AST_IRQ_LEVEL: assert property (
        (stat_val & mask_val) != 8'h00 |=> irq_o)
        else $error("interrupt not raised for unmasked status");

endmodule

`default_nettype wire

// [logic/pfb_flag_cell.sv]
// One flag bit: set by hardware, loaded by a write or a clearing strobe.
// Assumes set and load are single-cycle signals on clk_i.
`timescale 1ns/1ps
`default_nettype none

module pfb_flag_cell (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic set_i,
    input  wire logic wr_i,
    input  wire logic wd_i,
    output var  logic q_o
);
    logic q_next;

    // A set arriving with a clearing write is kept, so no event is lost.
    assign q_next = set_i ? 1'b1 : (wr_i ? wd_i : q_o);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= 1'b0;
        end else begin
            q_o <= q_next;
        end
    end
endmodule

`default_nettype wire

// [logic/pfb_irq_status.sv]
// Sticky event status with write-one-to-clear, a mask and one level interrupt.
// Assumes events and clears are single-cycle vectors on clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "pfb_defines.svh"

module pfb_irq_status (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] evt_i,
    input  wire logic [7:0] w1c_i,
    input  wire logic       mask_we_i,
    input  wire logic [7:0] mask_wd_i,
    output var  logic [7:0] stat_o,
    output var  logic [7:0] mask_o,
    output var  logic       irq_o
);
    logic [7:0] stat_next;

    // The event term comes last so a set beats a clear in the same cycle.
    assign stat_next = (stat_o & ~w1c_i) | evt_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_o <= `PFB_RST_STAT;
            mask_o <= `PFB_RST_MASK;
            irq_o  <= 1'b0;
        end else begin
            stat_o <= stat_next;
            if (mask_we_i) begin
                mask_o <= mask_wd_i;
            end
            irq_o <= |(stat_o & mask_o);
        end
    end
endmodule

`default_nettype wire

// [pkg/pfb_defines.svh]
// Constants of the peripheral interrupt flag bank: offsets, bit positions and reset values.
// Assumes it is included by its bare name from the design files and the testbench.
`ifndef PFB_DEFINES_SVH
`define PFB_DEFINES_SVH

// Byte addresses of the word registers on the register bus.
`define PFB_OFS_FLAG      8'h00
`define PFB_OFS_CTRL      8'h04
`define PFB_OFS_STAT      8'h08
`define PFB_OFS_MASK      8'h0C

// Bit positions inside the flag register and the status and mask registers.
`define PFB_BIT_PSP       7
`define PFB_BIT_CONV      6
`define PFB_BIT_RX        5
`define PFB_BIT_TX        4
`define PFB_BIT_SYNC      3
`define PFB_BIT_CCP       2
`define PFB_BIT_TMRB      1
`define PFB_BIT_TMRA      0

// Software may write these flag bits; the receive and transmit bits are read-only.
`define PFB_FLAG_WMASK    8'hCF

// Control register fields.
`define PFB_CTRL_PSP_BIT  0
`define PFB_CTRL_MODE_LO  1
`define PFB_CTRL_MODE_HI  2

// Reset values.
`define PFB_RST_FLAG      8'h00
`define PFB_RST_CTRL      8'h01
`define PFB_RST_STAT      8'h00
`define PFB_RST_MASK      8'h00

`endif

// [pkg/pfb_pkg.sv]
// Types shared by the peripheral interrupt flag bank.
// Assumes the defines header sits next to it on the include path.
package pfb_pkg;

    // Capture/compare unit mode as software selects it.
    typedef enum logic [1:0] {
        PFB_CCP_CAPTURE = 2'b00,
        PFB_CCP_COMPARE = 2'b01,
        PFB_CCP_PWM     = 2'b10,
        PFB_CCP_OFF     = 2'b11
    } pfb_ccp_mode_t;

    // One-cycle event strobes from the on-chip peripherals, all on clk_i.
    typedef struct packed {
        logic psp_access;
        logic conv_done;
        logic rx_load;
        logic rx_read;
        logic tx_drain;
        logic tx_write;
        logic sync_done;
        logic ccp_capture;
        logic ccp_compare;
        logic tmr_b_match;
        logic tmr_a_ovf;
    } pfb_evt_t;

endpackage

// [testbench/pfb_flag_bank_tb.sv]
// Self-checking bench for the peripheral flag bank: Wishbone register tasks and event scenarios.
// Assumes the design acks one cycle after a request and that events come from the peripheral model.
`timescale 1ns/1ps
`default_nettype none
`include "pfb_defines.svh"

module pfb_flag_bank_tb;
    import pfb_pkg::*;

    localparam logic [10:0] EV_PSP = 11'h400;
    localparam logic [10:0] EV_CONV = 11'h200;
    localparam logic [10:0] EV_RXL = 11'h100;
    localparam logic [10:0] EV_RXR = 11'h080;
    localparam logic [10:0] EV_TXD = 11'h040;
    localparam logic [10:0] EV_TXW = 11'h020;
    localparam logic [10:0] EV_SYNC = 11'h010;
    localparam logic [10:0] EV_CAP = 11'h008;
    localparam logic [10:0] EV_CMP = 11'h004;
    localparam logic [10:0] EV_TMB = 11'h002;
    localparam logic [10:0] EV_TMA = 11'h001;

    logic        clk;
    logic        rst;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [10:0] req;
    pfb_evt_t    evt;
    logic [7:0]  flags_o;
    logic        irq_o;
    int          n_fail;
    int          checks;
    int          cycles;

    pfb_periph_model i_periph (
        .clk_i (clk),
        .rst_i (rst),
        .req_i (req),
        .evt_o (evt)
    );

    pfb_flag_bank i_dut (
        .clk_i    (clk),
        .rst_i    (rst),
        .wb_cyc_i (cyc),
        .wb_stb_i (stb),
        .wb_we_i  (we),
        .wb_adr_i (adr),
        .wb_sel_i (sel),
        .wb_dat_i (dat),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .evt_i    (evt),
        .flags_o  (flags_o),
        .irq_o    (irq_o)
    );

    always #10 clk = ~clk;

    task automatic finish_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // A hung bus or a stuck scenario ends here rather than running forever.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_fail = n_fail + 1;
            finish_test();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks = checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= wd;
        sel <= 4'hF;
        // Only the bench timeout ends the wait for a slave that never answers.
        @(posedge clk);
        while (wb_ack_o !== 1'b1) begin
            @(posedge clk);
        end
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        wb_xfer(1'b1, a, d, v);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        wb_xfer(1'b0, a, 32'h0, v);
        chk(name, exp, v);
    endtask

    // One request cycle becomes one strobe; the wait covers flag, status and interrupt latency.
    task automatic fire(input logic [10:0] e);
        req <= e;
        @(posedge clk);
        req <= 11'h000;
        repeat (4) @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        dat = 32'h0;
        req = 11'h000;
        n_fail = 0;
        checks = 0;
        cycles = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk("flag reset", `PFB_OFS_FLAG, 32'h00);
        rd_chk("ctrl reset", `PFB_OFS_CTRL, 32'h01);
        rd_chk("stat reset", `PFB_OFS_STAT, 32'h00);
        rd_chk("mask reset", `PFB_OFS_MASK, 32'h00);
        wr(8'h10, 32'hFF);
        rd_chk("unmapped", 8'h10, 32'h00);
        // Sticky events with every interrupt masked must still be visible to a polling loop.
        fire(EV_PSP);
        fire(EV_CONV);
        fire(EV_SYNC);
        fire(EV_TMB);
        fire(EV_TMA);
        rd_chk("flags polled", `PFB_OFS_FLAG, 32'hCB);
        chk("flags port", 32'hCB, {24'h0, flags_o});
        chk("irq masked", 32'h0, {31'h0, irq_o});
        rd_chk("stat polled", `PFB_OFS_STAT, 32'hCB);
        repeat (5) @(posedge clk);
        rd_chk("flags held", `PFB_OFS_FLAG, 32'hCB);
        wr(`PFB_OFS_FLAG, 32'h00);
        rd_chk("flags cleared", `PFB_OFS_FLAG, 32'h00);
        fire(EV_RXL);
        fire(EV_TXD);
        wr(`PFB_OFS_FLAG, 32'h00);
        rd_chk("rx tx read only", `PFB_OFS_FLAG, 32'h30);
        fire(EV_RXR);
        rd_chk("rx cleared by read", `PFB_OFS_FLAG, 32'h10);
        fire(EV_TXW);
        rd_chk("tx cleared by write", `PFB_OFS_FLAG, 32'h00);
        for (int m = 0; m < 4; m++) begin
            wr(`PFB_OFS_CTRL, 32'(m * 2 + 1));
            fire(EV_CAP);
            rd_chk("ccp capture", `PFB_OFS_FLAG, (m == 0) ? 32'h04 : 32'h00);
            wr(`PFB_OFS_FLAG, 32'h00);
            fire(EV_CMP);
            rd_chk("ccp compare", `PFB_OFS_FLAG, (m == 1) ? 32'h04 : 32'h00);
            wr(`PFB_OFS_FLAG, 32'h00);
        end
        // Without the parallel port the top bit must refuse both the event and a software write.
        wr(`PFB_OFS_CTRL, 32'h00);
        fire(EV_PSP);
        wr(`PFB_OFS_FLAG, 32'h80);
        rd_chk("psp absent", `PFB_OFS_FLAG, 32'h00);
        wr(`PFB_OFS_STAT, 32'hFF);
        rd_chk("stat w1c", `PFB_OFS_STAT, 32'h00);
        wr(`PFB_OFS_MASK, 32'h01);
        rd_chk("mask write", `PFB_OFS_MASK, 32'h01);
        fire(EV_TMA);
        chk("irq raised", 32'h1, {31'h0, irq_o});
        wr(`PFB_OFS_MASK, 32'h00);
        repeat (2) @(posedge clk);
        chk("irq masked off", 32'h0, {31'h0, irq_o});
        wr(`PFB_OFS_MASK, 32'h01);
        repeat (2) @(posedge clk);
        chk("irq unmasked", 32'h1, {31'h0, irq_o});
        wr(`PFB_OFS_STAT, 32'h01);
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq_o});
        rd_chk("flag after w1c", `PFB_OFS_FLAG, 32'h01);
        // A reset in mid-run must bring the set flag, the control and the mask back to power-on values.
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("irq after reset", 32'h0, {31'h0, irq_o});
        rd_chk("flag after reset", `PFB_OFS_FLAG, 32'h00);
        rd_chk("ctrl after reset", `PFB_OFS_CTRL, 32'h01);
        rd_chk("mask after reset", `PFB_OFS_MASK, 32'h00);
        finish_test();
    end
endmodule

`default_nettype wire

// [testbench/pfb_periph_model.sv]
// Stand-in for the on-chip peripherals that raise the flag bank's event strobes.
// Assumes the bench presents a request vector for exactly one cycle, changed at the rising edge.
`timescale 1ns/1ps
`default_nettype none

module pfb_periph_model (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic [10:0]       req_i,
    output var  pfb_pkg::pfb_evt_t evt_o
);
    import pfb_pkg::*;

    // Every event leaves as a one-cycle strobe; a request held longer would look like repeated events.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_o <= '0;
        end else begin
            evt_o <= pfb_evt_t'(req_i);
        end
    end
endmodule

`default_nettype wire
